/* common/serial_rx_cfg.svh */
`ifndef SERIAL_RX_CFG_SVH
`define SERIAL_RX_CFG_SVH

// Register byte offsets on the bus.
`define OFS_CTRL       8'h00
`define OFS_MODE       8'h04
`define OFS_BAUD       8'h08
`define OFS_DATA       8'h0c
`define OFS_IRQ_STAT   8'h10
`define OFS_IRQ_MASK   8'h14

// Control register field positions.
`define CTRL_PORT_EN   7
`define CTRL_NINE      6
`define CTRL_SINGLE    5
`define CTRL_CONT      4
`define CTRL_ADDR_DET  3
`define CTRL_FRAME_ERR 2
`define CTRL_OVERRUN   1
`define CTRL_NINTH     0

// Mode register field positions.
`define MODE_SYNC      0
`define MODE_MASTER    1

// Interrupt status and mask field positions.
`define IRQ_RX_LOAD    0
`define IRQ_FRAME      1
`define IRQ_OVERRUN    2

// Reset values.
`define CTRL_RESET     8'h00
`define MODE_RESET     2'h0
`define MASK_RESET     3'h0

// Timing: clock rate, default line rate and the derived bit period less one.
`define CLK_HZ         50000000
`define BAUD_RATE      115200
`define BAUD_DIV       ((`CLK_HZ / `BAUD_RATE) - 1)

`endif

/* common/serial_rx_pkg.sv */
package serial_rx_pkg;

	typedef enum logic [1:0]
	{
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_t;

	typedef logic [8:0] rx_word_t;

endpackage

/* design/serial_receive_control.sv */
// Operation
// - Enable bit hands data and clock pins to the port; cleared holds port in reset.
// - Nine-bit select picks nine data bits per frame, else eight.
// - Sync master: single-receive takes one word, then hardware clears it; else ignored.
// - Async: continuous-receive bit enables or disables the receiver.
// - Sync: continuous-receive runs word after word and overrides single-receive.
// - Async nine-bit with address detect: load and interrupt only if ninth bit set.
// - Async nine-bit without address detect: accept all, ninth bit to software.
// - Async eight-bit: address detect ignored, every frame received.
// - Bad stop bit flags framing error, updated at next loaded frame, read-only.
// - Frame arriving over unread data sets overrun only while continuous-receive is set; clearing continuous-receive clears it.
`include "serial_rx_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module serial_receive_control
#(
	parameter logic [15:0] BAUD_DIV_RESET = 16'(`BAUD_DIV)
)
(
	// Clock, reset and clock enable.
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	input  wire logic                   ce,
	// Classic Wishbone slave.
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic                        wb_ack_o,
	output logic      [31:0]            wb_dat_o,
	// Serial line pins.
	input  wire logic                   rx_data_pin,
	input  wire logic                   tx_clock_pin_i,
	output logic                        tx_clock_pin_o,
	output logic                        tx_clock_pin_oe,
	// Interrupt.
	output logic                        irq
);
	import serial_rx_pkg::*;

	rx_state_t                  state_reg;
	rx_state_t                  state_next;
	logic       [7:0]           ctrl_reg;
	logic       [1:0]           mode_reg;
	logic       [15:0]          baud_reg;
	logic       [2:0]           stat_reg;
	logic       [2:0]           mask_reg;
	logic       [15:0]          cnt_reg;
	logic       [3:0]           bit_reg;
	rx_word_t                   receive_shift_register_reg;
	rx_word_t                   receive_buffer_reg;
	logic                       valid_reg;
	logic                       rx_s1_reg;
	logic                       rx_s2_reg;
	logic                       ck_s1_reg;
	logic                       ck_s2_reg;
	logic                       ck_s3_reg;

	// Bus decode.
	wire        req         = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land at the edge where the master samples ack, as a classic cycle expects.
	wire        wr          = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	wire        rd          = req & ~wb_we_i;
	wire        hit_ctrl    = wb_adr_i == `OFS_CTRL;
	wire        hit_mode    = wb_adr_i == `OFS_MODE;
	wire        hit_baud    = wb_adr_i == `OFS_BAUD;
	wire        hit_data    = wb_adr_i == `OFS_DATA;
	wire        hit_stat    = wb_adr_i == `OFS_IRQ_STAT;
	wire        hit_mask    = wb_adr_i == `OFS_IRQ_MASK;
	wire        wr_ctrl     = wr & hit_ctrl & wb_sel_i[0];
	wire        pop         = rd & hit_data;

	// Mode decode.
	wire        port_enable               = ctrl_reg[`CTRL_PORT_EN];
	wire        nine_bit_rx_select        = ctrl_reg[`CTRL_NINE];
	wire        single_receive_enable     = ctrl_reg[`CTRL_SINGLE];
	wire        continuous_receive_enable = ctrl_reg[`CTRL_CONT];
	wire        address_detect_enable     = ctrl_reg[`CTRL_ADDR_DET];
	wire        framing_error_flag        = ctrl_reg[`CTRL_FRAME_ERR];
	wire        overrun_error_flag        = ctrl_reg[`CTRL_OVERRUN];
	wire        sync_mode   = mode_reg[`MODE_SYNC];
	wire        master_mode = mode_reg[`MODE_MASTER];
	wire        sync_master = sync_mode & master_mode;

	// An overrun stalls the receiver until software clears continuous-receive.
	wire        rx_run = port_enable & ~overrun_error_flag &
		(continuous_receive_enable | (sync_master & single_receive_enable));

	wire        tick        = cnt_reg == 16'h0000;
	wire        ck_rise     = ck_s2_reg & ~ck_s3_reg;
	wire        sample      = sync_mode ? (sync_master ? (tick & ~tx_clock_pin_o) : ck_rise)
		: tick;
	wire [3:0]  last_bit    = nine_bit_rx_select ? 4'h8 : 4'h7;
	wire        frame_done  = (state_reg == RX_STOP) & (sync_mode | tick);
	wire        bad_stop    = ~sync_mode & ~rx_s2_reg;
	wire        addr_reject = ~sync_mode & nine_bit_rx_select & address_detect_enable
		& ~receive_shift_register_reg[8];
	wire        accept      = frame_done & ~addr_reject;
	wire        load        = accept & (~valid_reg | pop);
	wire        overrun_set = accept & valid_reg & ~pop;
	wire        single_done = frame_done & sync_master & ~continuous_receive_enable;

	function automatic logic [2:0] w1c_update(input logic [2:0] cur, input logic [2:0] set,
		input logic [2:0] clr);
		w1c_update = set | (cur & ~clr);
	endfunction

	wire [2:0]  stat_set = {overrun_set, load & bad_stop, load};
	wire [2:0]  stat_clr = (wr & hit_stat & wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;

	// Receiver sequencing.
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			RX_IDLE:
				if (sync_mode)
					state_next = RX_DATA;
				else if (~rx_s2_reg)
					state_next = RX_START;
			RX_START:
				if (tick)
					state_next = rx_s2_reg ? RX_IDLE : RX_DATA;
			RX_DATA:
				if (sample && bit_reg == last_bit)
					state_next = RX_STOP;
			RX_STOP:
				if (frame_done)
					state_next = RX_IDLE;
		endcase
		if (!rx_run)
			state_next = RX_IDLE;
	end

	wire [31:0] rd_data =
		hit_ctrl ? {24'h000000, ctrl_reg[7:1], receive_buffer_reg[8]} :
		hit_mode ? {30'h0, mode_reg} :
		hit_baud ? {16'h0000, baud_reg} :
		hit_data ? {23'h0, receive_buffer_reg} :
		hit_stat ? {29'h0, stat_reg} :
		hit_mask ? {29'h0, mask_reg} : 32'h00000000;

	// Wishbone answer: one wait state, unmapped addresses answer with zero.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else if (ce)
		begin
			wb_ack_o <= req;
			if (rd)
				wb_dat_o <= rd_data;
		end
	end

	// Software control; hardware clears single-receive and raises the error flags.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_reg <= `CTRL_RESET;
			mode_reg <= `MODE_RESET;
			baud_reg <= BAUD_DIV_RESET;
			mask_reg <= `MASK_RESET;
		end
		else if (ce)
		begin
			if (wr_ctrl)
				ctrl_reg[7:3] <= wb_dat_i[7:3];
			else if (single_done)
				ctrl_reg[`CTRL_SINGLE] <= 1'b0;
			if (!port_enable || !continuous_receive_enable)
				ctrl_reg[`CTRL_OVERRUN] <= 1'b0;
			else if (overrun_set)
				ctrl_reg[`CTRL_OVERRUN] <= 1'b1;
			if (!port_enable)
				ctrl_reg[`CTRL_FRAME_ERR] <= 1'b0;
			else if (load)
				ctrl_reg[`CTRL_FRAME_ERR] <= bad_stop;
			if (wr & hit_mode & wb_sel_i[0])
				mode_reg <= wb_dat_i[1:0];
			if (wr & hit_baud & wb_sel_i[0])
				baud_reg[7:0] <= wb_dat_i[7:0];
			if (wr & hit_baud & wb_sel_i[1])
				baud_reg[15:8] <= wb_dat_i[15:8];
			if (wr & hit_mask & wb_sel_i[0])
				mask_reg <= wb_dat_i[2:0];
		end
	end

	// Sticky events: a new event wins over a clear in the same cycle.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stat_reg <= 3'h0;
			irq      <= 1'b0;
		end
		else if (ce)
		begin
			stat_reg <= port_enable ? w1c_update(stat_reg, stat_set, stat_clr) : 3'h0;
			irq      <= port_enable & |(stat_reg & mask_reg);
		end
	end

	// Pin synchronisers.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			ck_s1_reg <= 1'b0;
			ck_s2_reg <= 1'b0;
			ck_s3_reg <= 1'b0;
		end
		else if (ce)
		begin
			rx_s1_reg <= rx_data_pin;
			rx_s2_reg <= rx_s1_reg;
			ck_s1_reg <= tx_clock_pin_i;
			ck_s2_reg <= ck_s1_reg;
			ck_s3_reg <= ck_s2_reg;
		end
	end

	// Bit timing. The start bit is checked at half a period so later samples land mid-bit.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_reg <= 16'h0000;
		else if (ce)
		begin
			if (state_next != state_reg && state_next == RX_START)
				cnt_reg <= {1'b0, baud_reg[15:1]};
			else if (state_reg == RX_IDLE || tick)
				cnt_reg <= baud_reg;
			else
				cnt_reg <= cnt_reg - 16'h0001;
		end
	end

	// Shift logic and the generated clock of synchronous master mode.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg                  <= RX_IDLE;
			bit_reg                    <= 4'h0;
			receive_shift_register_reg <= 9'h000;
			tx_clock_pin_o             <= 1'b0;
			tx_clock_pin_oe            <= 1'b0;
		end
		else if (ce)
		begin
			state_reg       <= state_next;
			tx_clock_pin_oe <= port_enable & sync_master;
			if (state_reg == RX_DATA && sync_master && tick)
				tx_clock_pin_o <= ~tx_clock_pin_o;
			else if (state_reg != RX_DATA)
				tx_clock_pin_o <= 1'b0;
			if (state_reg != RX_DATA)
				bit_reg <= 4'h0;
			else if (sample)
			begin
				bit_reg                             <= bit_reg + 4'h1;
				receive_shift_register_reg[bit_reg] <= rx_s2_reg;
			end
			if (state_next == RX_DATA && state_reg != RX_DATA)
				receive_shift_register_reg <= 9'h000;
		end
	end

	// Receive buffer: one word plus its ninth bit, read pops it.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			receive_buffer_reg <= 9'h000;
			valid_reg          <= 1'b0;
		end
		else if (ce)
		begin
			if (!port_enable)
				valid_reg <= 1'b0;
			else if (load)
			begin
				valid_reg          <= 1'b1;
				receive_buffer_reg <= nine_bit_rx_select ? receive_shift_register_reg
					: {1'b0, receive_shift_register_reg[7:0]};
			end
			else if (pop)
				valid_reg <= 1'b0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_disabled_idle;
		ce && !port_enable |=> state_reg == RX_IDLE && !tx_clock_pin_oe;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("port idle when disabled");

	property p_eight_bit_clean;
		ce && load && !nine_bit_rx_select |=> receive_buffer_reg[8] == 1'b0;
	endproperty
	a_eight_bit_clean: assert property (p_eight_bit_clean) else $error("ninth bit in 8-bit mode");

	property p_single_clears;
		ce && single_done && !wr_ctrl |=> !single_receive_enable;
	endproperty
	a_single_clears: assert property (p_single_clears) else $error("single receive kept");

	property p_async_off;
		ce && !sync_mode && !continuous_receive_enable |=> state_reg == RX_IDLE;
	endproperty
	a_async_off: assert property (p_async_off) else $error("async receiver ran while off");

	property p_cont_keeps_single;
		ce && frame_done && sync_mode && continuous_receive_enable && !wr_ctrl
			|=> single_receive_enable == $past(single_receive_enable);
	endproperty
	a_cont_keeps_single: assert property (p_cont_keeps_single) else $error("cont lost");

	property p_addr_gate;
		ce && frame_done && !sync_mode && nine_bit_rx_select && address_detect_enable
			&& !receive_shift_register_reg[8] |-> !load && !stat_set[0];
	endproperty
	a_addr_gate: assert property (p_addr_gate) else $error("non-address frame loaded");

	property p_accept_all;
		ce && port_enable && frame_done && !valid_reg && (!nine_bit_rx_select
			|| !address_detect_enable) |=> valid_reg;
	endproperty
	a_accept_all: assert property (p_accept_all) else $error("frame dropped");

	property p_frame_err;
		ce && port_enable && load |=> framing_error_flag == $past(bad_stop);
	endproperty
	a_frame_err: assert property (p_frame_err) else $error("framing flag wrong");

	property p_overrun;
		ce && port_enable && continuous_receive_enable && overrun_set |=> overrun_error_flag;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_disabled_quiet;
		(ce && !port_enable) [*2] |=> !irq && !framing_error_flag && !overrun_error_flag;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled port active");

endmodule

`default_nettype wire

/* tb/serial_line_partner.sv */
`timescale 1ns/100ps
`default_nettype none

module serial_line_partner
#(
	parameter int BIT_CYC = 4
)
(
	// Clock and line.
	input  wire logic clk,
	output logic      line
);
	// Idle high between frames, as a transmitter leaves the line.
	initial line = 1'b1;

	// Start bit, data LSB first, stop bit, then two idle bit times.
	task automatic send(input logic [8:0] w, input int nbits, input logic stop);
		@(posedge clk);
		for (int i = 0; i < nbits + 4; i++)
		begin
			line <= (i == 0) ? 1'b0 : (i <= nbits) ? w[i - 1] : (i == nbits + 1) ? stop : 1'b1;
			repeat (BIT_CYC) @(posedge clk);
		end
	endtask
endmodule

`default_nettype wire

/* tb/serial_receive_control_bench.sv */
`include "serial_rx_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module serial_receive_control_bench;
	logic        clk;
	logic        arst_n;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [31:0] wdat;
	logic        ack;
	logic [31:0] rdat;
	logic        rx;
	logic        ck_o;
	logic        ck_oe;
	logic        irq;
	logic        sck;
	logic        b9;
	logic [31:0] q;
	logic [31:0] c;
	logic [15:0] seed;
	logic [8:0]  w;
	int          acc;
	int          err_total;
	int          num_checks;
	int          exp_q[$];
	logic [7:0]  ofs[6] = '{`OFS_CTRL, `OFS_MODE, `OFS_BAUD, `OFS_IRQ_STAT, `OFS_IRQ_MASK, 8'h18};
	logic [31:0] rst[6] = '{32'h0, 32'h0, 32'(`BAUD_DIV), 32'h0, 32'h0, 32'h0};

	serial_receive_control i_dut(.clk(clk), .arst_n(arst_n), .ce(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_ack_o(ack), .wb_dat_o(rdat), .rx_data_pin(rx), .tx_clock_pin_i(sck),
		.tx_clock_pin_o(ck_o), .tx_clock_pin_oe(ck_oe), .irq(irq));

	serial_line_partner #(.BIT_CYC(4)) i_line(.clk(clk), .line(rx));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_pin(input string name, input logic exp, input logic got);
		chk(name, {31'h0, exp}, {31'h0, got});
	endtask

	// The request is held until ack is sampled high, then released.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 40);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			err_total++;
			conclude();
		end
		// Registered outputs such as irq follow an access one edge late; let them settle.
		repeat (2) @(negedge clk);
	endtask

	// Slave clock on the clock pin, one toggle every four cycles.
	task automatic toggle_clock(input int n);
		for (int t = 0; t < n; t++)
		begin
			repeat (4) @(posedge clk);
			sck <= ~sck;
		end
	endtask

	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(name, exp, q);
	endtask

	// Queues the word only if the receiver should accept it.
	task automatic frame(input logic nine, input logic adet, input logic stop);
		seed = lfsr(seed);
		w = seed[8:0];
		i_line.send(w, nine ? 9 : 8, stop);
		if (!nine || !adet || w[8])
			exp_q.push_back(nine ? int'(w) : int'(w[7:0]));
	endtask

	initial
	begin
		arst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		seed = 16'd15061;
		sck = 1'b0;
		b9 = 1'b0;
		err_total = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		foreach (ofs[i])
			rchk("reset value", ofs[i], rst[i]);
		$display("test reset values done");
		bus(1'b1, `OFS_BAUD, 32'h3);
		bus(1'b1, `OFS_IRQ_MASK, 32'h7);
		for (int m = 0; m < 4; m++)
			for (int k = 0; k < 4; k++)
			begin
				c = {24'h0, 1'b1, m[1], 2'b01, m[0], 3'b0};
				bus(1'b1, `OFS_CTRL, c);
				frame(m[1], m[0], 1'b1);
				acc = exp_q.size();
				rchk("status", `OFS_IRQ_STAT, acc);
				chk_pin("irq", acc[0], irq);
				if (acc != 0)
				begin
					b9 = exp_q[0][8];
					rchk("ctrl", `OFS_CTRL, c | exp_q[0][8]);
					bus(1'b1, `OFS_IRQ_STAT, 32'h1);
					rchk("data", `OFS_DATA, exp_q.pop_front());
				end
			end
		$display("test frame widths and address detect done");
		bus(1'b1, `OFS_CTRL, 32'h94);
		rchk("ctrl", `OFS_CTRL, 32'h90 | b9);
		frame(1'b0, 1'b0, 1'b0);
		rchk("ctrl", `OFS_CTRL, 32'h94);
		rchk("status", `OFS_IRQ_STAT, 32'h3);
		rchk("data", `OFS_DATA, exp_q.pop_front());
		frame(1'b0, 1'b0, 1'b1);
		rchk("ctrl", `OFS_CTRL, 32'h90);
		rchk("data", `OFS_DATA, exp_q.pop_front());
		$display("test framing error done");
		bus(1'b1, `OFS_IRQ_STAT, 32'h7);
		frame(1'b0, 1'b0, 1'b1);
		frame(1'b0, 1'b0, 1'b1);
		exp_q.delete();
		rchk("ctrl", `OFS_CTRL, 32'h92);
		rchk("status", `OFS_IRQ_STAT, 32'h5);
		chk_pin("irq", 1'b1, irq);
		bus(1'b1, `OFS_IRQ_MASK, 32'h0);
		chk_pin("irq masked", 1'b0, irq);
		bus(1'b1, `OFS_CTRL, 32'h80);
		rchk("ctrl", `OFS_CTRL, 32'h80);
		bus(1'b1, `OFS_IRQ_MASK, 32'h7);
		chk_pin("irq", 1'b1, irq);
		bus(1'b1, `OFS_CTRL, 32'h0);
		rchk("status", `OFS_IRQ_STAT, 32'h0);
		chk_pin("irq", 1'b0, irq);
		$display("test overrun and disable done");
		bus(1'b1, `OFS_CTRL, 32'ha0);
		frame(1'b0, 1'b0, 1'b1);
		exp_q.delete();
		rchk("status", `OFS_IRQ_STAT, 32'h0);
		rchk("ctrl", `OFS_CTRL, 32'ha0);
		bus(1'b1, `OFS_CTRL, 32'h0);
		bus(1'b1, `OFS_MODE, 32'h3);
		chk_pin("clock enable", 1'b0, ck_oe);
		bus(1'b1, `OFS_CTRL, 32'ha0);
		chk_pin("clock enable", 1'b1, ck_oe);
		for (int n = 0; n < 60 && q[5] !== 1'b0; n++)
			bus(1'b0, `OFS_CTRL, 32'h0);
		chk("single done", 32'h0, q & 32'h20);
		chk_pin("clock idle", 1'b0, ck_o);
		rchk("data", `OFS_DATA, 32'hff);
		bus(1'b1, `OFS_CTRL, 32'hb0);
		repeat (300) @(posedge clk);
		bus(1'b0, `OFS_CTRL, 32'h0);
		chk("continuous", 32'h2, q & 32'h2);
		chk("single kept", 32'h20, q & 32'h20);
		$display("test synchronous receive done");
		bus(1'b1, `OFS_CTRL, 32'h0);
		bus(1'b1, `OFS_MODE, 32'h1);
		bus(1'b1, `OFS_CTRL, 32'ha0);
		toggle_clock(16);
		rchk("status", `OFS_IRQ_STAT, 32'h0);
		rchk("ctrl", `OFS_CTRL, 32'ha0);
		chk_pin("clock enable", 1'b0, ck_oe);
		bus(1'b1, `OFS_CTRL, 32'h90);
		toggle_clock(16);
		rchk("data", `OFS_DATA, 32'hff);
		$display("test synchronous slave done");
		conclude();
	end
endmodule

`default_nettype wire
